// [common/usb_ep_map.vh]
// Register map, field positions, reset values and codes of the endpoint DMA and test block.
// Assumes inclusion by bare name from the design files.
`ifndef USB_EP_MAP_VH
`define USB_EP_MAP_VH

// Register indices; the byte address is four times the index.
`define IDX_OUT_CSR 6'h00
`define IDX_OUT_MAXP 6'h01
`define IDX_IN_CSR 6'h02
`define IDX_OUT_COUNT 6'h03
`define IDX_INT_STAT 6'h04
`define IDX_INT_CLR 6'h05
`define IDX_INT_EN 6'h06
`define IDX_EP0_CSR 6'h07
`define IDX_TEST_MODE 6'h0f

// Field positions.
`define OUT_RDY_BIT 0
`define OUT_REQ_MODE_BIT 11
`define OUT_NYET_SUP_BIT 12
`define OUT_EARLY_BIT 14
`define IN_TOGGLE_BIT 0
`define IN_FRC_TOG_BIT 11
`define EP0_IN_RDY_BIT 1
`define MAXP_MSB 10

// Test mode one-hot codes.
`define TM_SE0_NAK 6'h01
`define TM_J 6'h02
`define TM_K 6'h04
`define TM_PACKET 6'h08

// Interrupt status bits.
`define INT_OUT_RX 0
`define INT_IN_SENT 1
`define INT_EP0_DONE 2
`define INT_W 3

// Handshake codes on the OUT handshake port.
`define HS_ACK 2'h0
`define HS_NAK 2'h1
`define HS_NYET 2'h2
`define HS_STALL 2'h3

// Other figures.
`define EARLY_BYTES 11'h010
`define TEST_PKT_LEN 6'h35
`define MAXP_RESET 11'h040

`endif

// [logic/test_pkt_replay.v]
// Replays the test packet held in the endpoint 0 FIFO again and again.
// Assumes the FIFO read port returns the byte at rd_addr in the same cycle.
`timescale 1ns/1ns
`include "usb_ep_map.vh"

module test_pkt_replay (
	input wire clk,
	input wire srst,
	input wire run,
	input wire [7:0] rd_data,
	input wire tx_ready,
	output reg [5:0] rd_addr_ff,
	output reg [7:0] tx_data_ff,
	output reg tx_valid_ff,
	output reg tx_last_ff
);

localparam S_IDLE = 3'b001;
localparam S_FETCH = 3'b010;
localparam S_SEND = 3'b100;

reg [2:0] state_ff;

////////////////////////////////////////////////////////////////////////////////
// The packet is never consumed, so software loads it only once.
always @(posedge clk) begin
	if (srst) begin
		state_ff <= S_IDLE;
		rd_addr_ff <= 6'h00;
		tx_data_ff <= 8'h00;
		tx_valid_ff <= 1'b0;
		tx_last_ff <= 1'b0;
	end else begin
		case (state_ff)
			S_IDLE: begin
				rd_addr_ff <= 6'h00;
				if (run) begin
					state_ff <= S_FETCH;
				end
			end
			S_FETCH: begin
				tx_data_ff <= rd_data;
				tx_valid_ff <= 1'b1;
				tx_last_ff <= (rd_addr_ff == `TEST_PKT_LEN - 6'h01);
				state_ff <= S_SEND;
			end
			S_SEND: begin
				if (tx_ready) begin
					tx_valid_ff <= 1'b0;
					tx_last_ff <= 1'b0;
					if (rd_addr_ff == `TEST_PKT_LEN - 6'h01) begin
						rd_addr_ff <= 6'h00; // R16
					end else begin
						rd_addr_ff <= rd_addr_ff + 6'h01;
					end
					state_ff <= run ? S_FETCH : S_IDLE;
				end
			end
			default: begin
				state_ff <= S_IDLE;
			end
		endcase
	end
end

endmodule // test_pkt_replay

// [logic/usb_ep_dma_test.v]
// OUT endpoint DMA request, IN forced toggle, NYET suppression and high-speed test modes.
// Assumes an APB master, a packet engine that reports receive and send events as
// one-cycle pulses, and a FIFO side that pulses one strobe per byte read.
`timescale 1ns/1ns
`include "usb_ep_map.vh"

// Operation
// R1: OUT CSR bit 11 picks request mode
// R2: Mode 0 requests while packet waits
// R3: Drop at last byte, early, or clear
// R4: Mode 1 requests only for full packets
// R5: Short packet in mode 1 stays, interrupts
// R6: Mode 1 to 0 releases held packet
// R7: Bulk splits into max packets, short ends
// R8: Forced toggle flips data bit always
// R9: Suppress bit forbids NYET at high speed
// R10: Test mode register at 0Fh enters modes
// R11: Software awaits endpoint 0 status interrupt
// R12: Code 01 NAKs every IN token
// R13: Code 02 drives continuous J
// R14: Code 04 drives continuous K
// R15: Load packet, set ready, write 08
// R16: Packet test resends 53 bytes forever
// R17: Received packet sets ready flag, interrupts
// R18: Software programs max payload bits 10:0
// R19: Software sets one test bit only
module usb_ep_dma_test #(
	parameter MAXP_W = 11
) (
	input wire CLK_SYS,
	input wire SRST,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	output reg [31:0] PRDATA,
	output reg PREADY,
	output reg PSLVERR,
	input wire RX_PKT_DONE,
	input wire [MAXP_W-1:0] RX_PKT_LEN,
	input wire FIFO_RD_STB,
	output reg OUT_DMA_REQ,
	input wire OUT_HS_REQ,
	input wire HIGH_SPEED,
	input wire NO_ROOM_NEXT,
	output reg OUT_HS_VALID,
	output reg [1:0] OUT_HS_CODE,
	input wire IN_PKT_DONE,
	input wire IN_ACK_SEEN,
	output reg IN_DATA_TOGGLE,
	input wire IN_TOKEN,
	output reg IN_NAK_FORCE,
	output reg DRIVE_J,
	output reg DRIVE_K,
	input wire EP0_STATUS_DONE,
	input wire [7:0] EP0_RD_DATA,
	output wire [5:0] EP0_RD_ADDR,
	output wire [7:0] TEST_TX_DATA,
	output wire TEST_TX_VALID,
	output wire TEST_TX_LAST,
	input wire TEST_TX_READY,
	output reg IRQ
);

reg out_rdy_ff;
reg req_mode_ff;
reg nyet_sup_ff;
reg early_ff;
reg [MAXP_W-1:0] maxp_ff;
reg [MAXP_W-1:0] rx_len_ff;
reg [MAXP_W-1:0] remain_ff;
reg full_pkt_ff;
reg frc_tog_ff;
reg ep0_in_rdy_ff;
reg [5:0] test_mode_ff;
reg [`INT_W-1:0] int_stat_ff;
reg [`INT_W-1:0] int_en_ff;

wire acc = PSEL & PENABLE & ~PREADY;
wire wr = acc & PWRITE;
wire [5:0] idx = PADDR[7:2];

////////////////////////////////////////////////////////////////////////////////
// Register decode.
function is_mapped;
	input [5:0] i;
	begin
		is_mapped = (i <= `IDX_EP0_CSR) || (i == `IDX_TEST_MODE);
	end
endfunction

function hit;
	input [5:0] i;
	input [5:0] target;
	begin
		hit = (i == target);
	end
endfunction

function tm_has;
	input [5:0] mode;
	input [5:0] code;
	begin
		tm_has = |(mode & code);
	end
endfunction

function has_bytes;
	input [MAXP_W-1:0] count;
	begin
		has_bytes = (count != {MAXP_W{1'b0}});
	end
endfunction

// True when one more byte read brings the count down to the given level.
function reaches;
	input [MAXP_W-1:0] count;
	input [MAXP_W-1:0] level;
	begin
		reaches = (count == level + {{(MAXP_W-1){1'b0}}, 1'b1});
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Write strobes and the counted FIFO read.
wire out_csr_wr = wr & hit(idx, `IDX_OUT_CSR);
wire maxp_wr = wr & hit(idx, `IDX_OUT_MAXP);
wire in_csr_wr = wr & hit(idx, `IDX_IN_CSR);
wire int_clr_wr = wr & hit(idx, `IDX_INT_CLR);
wire int_en_wr = wr & hit(idx, `IDX_INT_EN);
wire ep0_csr_wr = wr & hit(idx, `IDX_EP0_CSR);
wire tm_wr = wr & hit(idx, `IDX_TEST_MODE);
// A strobe with nothing left to read is ignored, so a DMA that overshoots by one
// byte after the request falls cannot wrap the count.
wire rd_byte = FIFO_RD_STB & out_rdy_ff & has_bytes(remain_ff);

////////////////////////////////////////////////////////////////////////////////
// APB slave: one wait state, then a one-cycle PREADY.
// Writes take effect at the first access edge, one edge before PREADY is seen
// high; the master holds the request until then, so nothing is lost.
always @(posedge CLK_SYS) begin
	if (SRST) begin
		PREADY <= 1'b0;
		PSLVERR <= 1'b0;
		PRDATA <= 32'h00000000;
	end else begin
		PREADY <= acc;
		PSLVERR <= acc & ~is_mapped(idx);
		PRDATA <= 32'h00000000;
		if (acc & ~PWRITE) begin
			case (idx)
				`IDX_OUT_CSR: begin
					PRDATA[`OUT_RDY_BIT] <= out_rdy_ff;
					PRDATA[`OUT_REQ_MODE_BIT] <= req_mode_ff;
					PRDATA[`OUT_NYET_SUP_BIT] <= nyet_sup_ff;
					PRDATA[`OUT_EARLY_BIT] <= early_ff;
				end
				`IDX_OUT_MAXP: begin
					PRDATA[MAXP_W-1:0] <= maxp_ff;
				end
				`IDX_IN_CSR: begin
					PRDATA[`IN_TOGGLE_BIT] <= IN_DATA_TOGGLE;
					PRDATA[`IN_FRC_TOG_BIT] <= frc_tog_ff;
				end
				`IDX_OUT_COUNT: begin
					PRDATA[MAXP_W-1:0] <= rx_len_ff;
				end
				`IDX_INT_STAT: begin
					PRDATA[`INT_W-1:0] <= int_stat_ff;
				end
				`IDX_INT_EN: begin
					PRDATA[`INT_W-1:0] <= int_en_ff;
				end
				`IDX_EP0_CSR: begin
					PRDATA[`EP0_IN_RDY_BIT] <= ep0_in_rdy_ff;
				end
				`IDX_TEST_MODE: begin
					PRDATA[5:0] <= test_mode_ff;
				end
				default: begin
					PRDATA <= 32'h00000000;
				end
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// OUT endpoint control and packet-ready flag.
always @(posedge CLK_SYS) begin
	if (SRST) begin
		req_mode_ff <= 1'b0;
		nyet_sup_ff <= 1'b0;
		early_ff <= 1'b0;
		maxp_ff <= `MAXP_RESET;
		out_rdy_ff <= 1'b0;
		rx_len_ff <= {MAXP_W{1'b0}};
		remain_ff <= {MAXP_W{1'b0}};
		full_pkt_ff <= 1'b0;
	end else begin
		if (out_csr_wr) begin
			req_mode_ff <= PWDATA[`OUT_REQ_MODE_BIT]; // R1
			nyet_sup_ff <= PWDATA[`OUT_NYET_SUP_BIT];
			early_ff <= PWDATA[`OUT_EARLY_BIT];
			if (~PWDATA[`OUT_RDY_BIT]) begin
				out_rdy_ff <= 1'b0;
			end
		end
		if (maxp_wr) begin
			maxp_ff <= PWDATA[MAXP_W-1:0];
		end
		if (rd_byte) begin
			remain_ff <= remain_ff - {{(MAXP_W-1){1'b0}}, 1'b1};
		end
		// A packet is taken only while the FIFO is free, so a clear and a new packet
		// never meet on the flag; the engine NAKs while the flag stands.
		if (RX_PKT_DONE & ~out_rdy_ff) begin
			out_rdy_ff <= 1'b1; // R17
			rx_len_ff <= RX_PKT_LEN;
			remain_ff <= RX_PKT_LEN;
			full_pkt_ff <= (RX_PKT_LEN == maxp_ff); // R4 R7
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// DMA request line. It is a level recomputed every cycle, so a change from
// mode 1 to mode 0 raises it for a packet already held.
wire early_stop = early_ff & (remain_ff <= `EARLY_BYTES);
wire req_base = out_rdy_ff & has_bytes(remain_ff) & ~early_stop; // R3
wire nxt_dma_req = req_mode_ff ? (req_base & full_pkt_ff) : req_base; // R2 R4 R5 R6
// The register adds a cycle, so the read that reaches an end point drops the
// line at once; otherwise the DMA would be invited to take one byte more.
wire drop_last = rd_byte & reaches(remain_ff, {MAXP_W{1'b0}}); // R3
wire drop_early = rd_byte & early_ff & reaches(remain_ff, `EARLY_BYTES); // R3
// With early de-assert set, a packet of 16 bytes or fewer never raises the line
// and has to be read by software.

always @(posedge CLK_SYS) begin
	if (SRST) begin
		OUT_DMA_REQ <= 1'b0;
	end else begin
		OUT_DMA_REQ <= nxt_dma_req & ~drop_last & ~drop_early; // R3
	end
end

////////////////////////////////////////////////////////////////////////////////
// OUT handshake choice. A held packet means no room, so the answer is NAK.
always @(posedge CLK_SYS) begin
	if (SRST) begin
		OUT_HS_VALID <= 1'b0;
		OUT_HS_CODE <= `HS_ACK;
	end else begin
		OUT_HS_VALID <= OUT_HS_REQ;
		if (OUT_HS_REQ) begin
			if (out_rdy_ff) begin
				OUT_HS_CODE <= `HS_NAK;
			end else if (HIGH_SPEED & NO_ROOM_NEXT & ~nyet_sup_ff) begin
				OUT_HS_CODE <= `HS_NYET; // R9
			end else begin
				OUT_HS_CODE <= `HS_ACK;
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// IN data toggle.
always @(posedge CLK_SYS) begin
	if (SRST) begin
		frc_tog_ff <= 1'b0;
		IN_DATA_TOGGLE <= 1'b0;
	end else begin
		if (in_csr_wr) begin
			frc_tog_ff <= PWDATA[`IN_FRC_TOG_BIT];
		end
		if (IN_PKT_DONE & (IN_ACK_SEEN | frc_tog_ff)) begin
			IN_DATA_TOGGLE <= ~IN_DATA_TOGGLE; // R8
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Test modes. The outputs follow the register; no decode of multi-bit values
// is attempted, since only one code is meant to be set at a time.
always @(posedge CLK_SYS) begin
	if (SRST) begin
		test_mode_ff <= 6'h00;
		ep0_in_rdy_ff <= 1'b0;
		IN_NAK_FORCE <= 1'b0;
		DRIVE_J <= 1'b0;
		DRIVE_K <= 1'b0;
	end else begin
		if (tm_wr) begin
			test_mode_ff <= PWDATA[5:0]; // R10
		end
		if (ep0_csr_wr) begin
			ep0_in_rdy_ff <= PWDATA[`EP0_IN_RDY_BIT];
		end
		// IN_TOKEN is left unread: the packet engine NAKs each IN token itself
		// while IN_NAK_FORCE stands.
		IN_NAK_FORCE <= tm_has(test_mode_ff, `TM_SE0_NAK); // R12
		DRIVE_J <= tm_has(test_mode_ff, `TM_J); // R13
		DRIVE_K <= tm_has(test_mode_ff, `TM_K); // R14
	end
end

// Replay starts only once software has marked the loaded packet ready.
wire replay_run = tm_has(test_mode_ff, `TM_PACKET) & ep0_in_rdy_ff;

test_pkt_replay i_test_pkt_replay (
	.clk(CLK_SYS),
	.srst(SRST),
	.run(replay_run),
	.rd_data(EP0_RD_DATA),
	.tx_ready(TEST_TX_READY),
	.rd_addr_ff(EP0_RD_ADDR),
	.tx_data_ff(TEST_TX_DATA),
	.tx_valid_ff(TEST_TX_VALID),
	.tx_last_ff(TEST_TX_LAST)
); // R16

////////////////////////////////////////////////////////////////////////////////
// Interrupts: sticky status, write-one-to-clear, set wins over clear.
wire [`INT_W-1:0] int_set = {EP0_STATUS_DONE, IN_PKT_DONE, RX_PKT_DONE & ~out_rdy_ff};
wire [`INT_W-1:0] int_clr = int_clr_wr ? PWDATA[`INT_W-1:0] : {`INT_W{1'b0}};
wire [`INT_W-1:0] nxt_int_stat = (int_stat_ff & ~int_clr) | int_set; // R5 R17

always @(posedge CLK_SYS) begin
	if (SRST) begin
		int_stat_ff <= {`INT_W{1'b0}};
		int_en_ff <= {`INT_W{1'b0}};
		IRQ <= 1'b0;
	end else begin
		int_stat_ff <= nxt_int_stat;
		if (int_en_wr) begin
			int_en_ff <= PWDATA[`INT_W-1:0];
		end
		IRQ <= |(nxt_int_stat & int_en_ff);
	end
end

endmodule // usb_ep_dma_test

// [test/usb_ep_dma_test_properties.sv]
// Port checker of the endpoint DMA and test block.
// Assumes it is bound to usb_ep_dma_test.
`timescale 1ns/1ns
`include "usb_ep_map.vh"
module usb_ep_dma_test_properties (
	input wire CLK_SYS,
	input wire SRST,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	input wire PREADY,
	input wire RX_PKT_DONE,
	input wire OUT_DMA_REQ,
	input wire OUT_HS_REQ,
	input wire HIGH_SPEED,
	input wire OUT_HS_VALID,
	input wire [1:0] OUT_HS_CODE,
	input wire IN_PKT_DONE,
	input wire IN_ACK_SEEN,
	input wire IN_DATA_TOGGLE,
	input wire IN_NAK_FORCE,
	input wire DRIVE_J,
	input wire DRIVE_K,
	input wire [7:0] TEST_TX_DATA,
	input wire TEST_TX_VALID,
	input wire TEST_TX_READY
);
wire [2:0] tm_bits = PWDATA[2:0];
wire wr_done = PSEL && PENABLE && PREADY && PWRITE;
default clocking @(posedge CLK_SYS); endclocking
default disable iff (SRST);
sequence s_fs_ask;
	OUT_HS_REQ && !HIGH_SPEED;
endsequence
sequence s_tm_write;
	wr_done && PADDR == 8'h3c;
endsequence
a_hs_answer: assert property (OUT_HS_REQ |=> OUT_HS_VALID) else $error("late handshake");
a_nyet_fs: assert property (s_fs_ask |=> OUT_HS_CODE != `HS_NYET) else $error("nyet");
a_tm_outputs: assert property (s_tm_write |=>
	{DRIVE_K, DRIVE_J, IN_NAK_FORCE} == $past(tm_bits)) else $error("test mode outputs");
a_tog_ack: assert property (IN_PKT_DONE && IN_ACK_SEEN |=>
	IN_DATA_TOGGLE != $past(IN_DATA_TOGGLE)) else $error("no toggle");
a_tog_idle: assert property (!IN_PKT_DONE |=> $stable(IN_DATA_TOGGLE)) else $error("toggle");
a_req_cause: assert property ($rose(OUT_DMA_REQ) |-> $past(RX_PKT_DONE, 2)
	|| $past(PSEL && PWRITE, 2)) else $error("request without cause");
a_drop_clear: assert property (wr_done && PADDR == 8'h00 && !PWDATA[0]
	|=> !OUT_DMA_REQ) else $error("request after clear");
a_tx_hold: assert property (TEST_TX_VALID && !TEST_TX_READY && !PSEL && !$past(PSEL)
	|=> TEST_TX_VALID && $stable(TEST_TX_DATA)) else $error("test byte dropped");
endmodule // usb_ep_dma_test_properties
bind usb_ep_dma_test usb_ep_dma_test_properties i_props (.CLK_SYS(CLK_SYS), .SRST(SRST),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
	.PREADY(PREADY), .RX_PKT_DONE(RX_PKT_DONE), .OUT_DMA_REQ(OUT_DMA_REQ),
	.OUT_HS_REQ(OUT_HS_REQ), .HIGH_SPEED(HIGH_SPEED), .OUT_HS_VALID(OUT_HS_VALID),
	.OUT_HS_CODE(OUT_HS_CODE), .IN_PKT_DONE(IN_PKT_DONE), .IN_ACK_SEEN(IN_ACK_SEEN),
	.IN_DATA_TOGGLE(IN_DATA_TOGGLE), .IN_NAK_FORCE(IN_NAK_FORCE), .DRIVE_J(DRIVE_J),
	.DRIVE_K(DRIVE_K), .TEST_TX_DATA(TEST_TX_DATA), .TEST_TX_VALID(TEST_TX_VALID),
	.TEST_TX_READY(TEST_TX_READY));

// [test/dma_fifo_model.sv]
// DMA controller and endpoint 0 FIFO standing at the far side of the block.
// Assumes one clock; it reads a byte per strobe while the request is up.
`timescale 1ns/1ns
module dma_fifo_model (
	input wire clk,
	input wire srst,
	input wire slow,
	input wire dma_req,
	output logic rd_stb,
	output int rd_cnt,
	input wire [5:0] ep0_addr,
	output wire [7:0] ep0_data,
	output logic tx_ready
);
// A simple pattern stands in for the loaded packet, so each byte shows its place.
assign ep0_data = 8'ha0 ^ {2'h0, ep0_addr};
always @(posedge clk) begin
	rd_stb <= dma_req && !srst && (!slow || $urandom % 2 == 0);
	rd_cnt <= srst ? 0 : rd_cnt + 32'(rd_stb);
	tx_ready <= !slow || $urandom % 3 != 0;
end
endmodule // dma_fifo_model

// [test/tb_usb_ep_dma_test.sv]
// Self-checking bench of the endpoint DMA and test block.
// Assumes the far side model and the bound checker.
`timescale 1ns/1ns
`include "usb_ep_map.vh"
module tb_usb_ep_dma_test;
logic clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0, rxd = 0, hsr = 0, hs = 0, nr = 0;
logic ind = 0, ack = 0, tok = 0, eps = 0, slw = 0, md, ie, er, tg = 0;
logic [7:0] pa = 0;
logic [10:0] n = 0;
logic [31:0] pw = 0, rd;
int failures = 0, checks_done = 0, cyc = 0, c0, k, e, ln, fcnt;
wire [31:0] prd;
wire rdy, err, dreq, stb, hsv, tgl, nakf, drj, drk, tvl, tlst, trd, irq;
wire [1:0] hsc;
wire [5:0] ea;
wire [7:0] ed, td;
usb_ep_dma_test i_usb_ep_dma_test (.CLK_SYS(clk), .SRST(srst), .PSEL(psel), .PENABLE(pen),
	.PWRITE(pwr), .PADDR(pa), .PWDATA(pw), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err),
	.RX_PKT_DONE(rxd), .RX_PKT_LEN(n), .FIFO_RD_STB(stb), .OUT_DMA_REQ(dreq),
	.OUT_HS_REQ(hsr), .HIGH_SPEED(hs), .NO_ROOM_NEXT(nr), .OUT_HS_VALID(hsv),
	.OUT_HS_CODE(hsc), .IN_PKT_DONE(ind), .IN_ACK_SEEN(ack), .IN_DATA_TOGGLE(tgl),
	.IN_TOKEN(tok), .IN_NAK_FORCE(nakf), .DRIVE_J(drj), .DRIVE_K(drk),
	.EP0_STATUS_DONE(eps), .EP0_RD_DATA(ed), .EP0_RD_ADDR(ea), .TEST_TX_DATA(td),
	.TEST_TX_VALID(tvl), .TEST_TX_LAST(tlst), .TEST_TX_READY(trd), .IRQ(irq));
dma_fifo_model i_dma_fifo_model (.clk(clk), .srst(srst), .slow(slw), .dma_req(dreq),
	.rd_stb(stb), .rd_cnt(fcnt), .ep0_addr(ea), .ep0_data(ed), .tx_ready(trd));
always #2 clk = ~clk;
////////////////////////////////////////////////////////////////
task chk(input logic [31:0] g, input logic [31:0] x);
	checks_done++;
	if (g !== x) begin
		failures++;
		$display("[FAIL] t=%0t got %h exp %h", $time, g, x);
	end
endtask
task apb(input logic w, input logic [5:0] a, input logic [31:0] d);
	@(posedge clk);
	psel <= 1;
	pwr <= w;
	pa <= {a, 2'h0};
	pw <= d;
	@(posedge clk);
	pen <= 1;
	do @(posedge clk); while (rdy !== 1);
	rd = prd;
	er = err;
	psel <= 0;
	pen <= 0;
endtask
task fin;
	@(posedge clk);
	hsr <= 0;
	ind <= 0;
	@(posedge clk);
endtask
task tally_and_finish;
	$display("checks %0d failures %0d", checks_done, failures);
	if (failures == 0 && checks_done > 0)
		$display("TB: PASS");
	else
		$display("TB: FAIL");
	$finish;
endtask
always @(posedge clk) begin
	cyc++;
	if (cyc == 6000) begin
		failures++;
		tally_and_finish;
	end
end
initial begin
	void'($urandom(26217));
	repeat (20) @(posedge clk);
	srst <= 0;
	apb(0, `IDX_TEST_MODE, 0);
	chk(rd, 0);
	apb(0, `IDX_OUT_MAXP, 0);
	chk(rd, 32'h40);
	apb(1, `IDX_OUT_MAXP, 32'h200);
	apb(0, `IDX_OUT_MAXP, 0);
	chk(rd, 32'h200);
	apb(1, `IDX_OUT_MAXP, 32'h40);
	apb(1, 6'h20, 32'h1);
	chk({31'h0, er}, 32'h1);
	$display("reset test done");
	for (k = 0; k < 6; k++) begin
		md = k > 2;
		ln = k % 3 == 2 ? 1 + $urandom % 63 : 64;
		ie = k != 2;
		slw <= k[0];
		apb(1, `IDX_INT_EN, {31'h0, ie});
		apb(1, `IDX_OUT_CSR, {17'h0, k % 3 == 1, 2'h0, md, 11'h0});
		@(posedge clk);
		rxd <= 1;
		n <= 11'(ln);
		@(posedge clk);
		rxd <= 0;
		c0 = fcnt;
		repeat (2) @(posedge clk);
		chk({31'h0, dreq}, {31'h0, md ? ln == 64 : 1'b1});
		chk({31'h0, irq}, {31'h0, ie});
		if (md && ln != 64) begin
			apb(1, `IDX_OUT_CSR, 32'h1);
			@(posedge clk);
			chk({31'h0, dreq}, 32'h1);
		end
		do @(posedge clk); while (dreq !== 0);
		repeat (2) @(posedge clk);
		e = fcnt - c0;
		chk({31'h0, k % 3 == 1 ? e >= ln - 16 && e <= ln - 15 : e >= ln && e <= ln + 1}, 32'h1);
		hsr <= 1;
		fin;
		chk({30'h0, hsc}, {30'h0, `HS_NAK});
		apb(1, `IDX_OUT_CSR, {20'h0, md, 11'h0});
		apb(1, `IDX_INT_CLR, 32'h1);
		@(posedge clk);
		chk({31'h0, irq}, 32'h0);
	end
	$display("dma test done");
	for (k = 0; k < 8; k++) begin
		apb(1, `IDX_OUT_CSR, {19'h0, k[2], 12'h0});
		@(posedge clk);
		hs <= k[1];
		nr <= k[0];
		hsr <= 1;
		fin;
		chk({31'h0, hsv}, 32'h1);
		chk({30'h0, hsc}, {30'h0, k[1:0] == 3 && !k[2] ? `HS_NYET : `HS_ACK});
		apb(1, `IDX_IN_CSR, {20'h0, k[2], 11'h0});
		@(posedge clk);
		ind <= 1;
		ack <= k[0];
		fin;
		tg = tg ^ (k[2] | k[0]);
		chk({31'h0, tgl}, {31'h0, tg});
	end
	$display("handshake test done");
	@(posedge clk);
	eps <= 1;
	@(posedge clk);
	eps <= 0;
	apb(0, `IDX_INT_STAT, 0);
	chk(rd & 32'h4, 32'h4);
	for (k = 0; k < 3; k++) begin
		apb(1, `IDX_TEST_MODE, 32'h1 << k);
		@(posedge clk);
		chk({29'h0, drk, drj, nakf}, 32'h1 << k);
	end
	apb(1, `IDX_EP0_CSR, 32'h2);
	apb(1, `IDX_TEST_MODE, 32'h8);
	for (e = 0; e < 120; ) begin
		@(posedge clk);
		if (tvl && trd) begin
			chk({24'h0, td}, {24'h0, 8'ha0 ^ 8'(e % 53)});
			chk({31'h0, tlst}, {31'h0, e % 53 == 52});
			e++;
		end
	end
	apb(1, `IDX_TEST_MODE, 0);
	$display("test mode test done");
	tally_and_finish;
end
endmodule // tb_usb_ep_dma_test
